// [design/phy_ext_pkg.sv]
package phy_ext_pkg;

   // bus geometry
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          REG_W           = 16;
   localparam int          IDX_W           = 6;
   localparam int          NUM_EVENTS      = 11;

   // register indices, byte address is four times the index
   localparam logic [5:0]  IDX_PART_ID     = 6'h12;
   localparam logic [5:0]  IDX_ENTROPY     = 6'h13;
   localparam logic [5:0]  IDX_EVENT_MASK  = 6'h1C;
   localparam logic [5:0]  IDX_EVENT_PEND  = 6'h1D;
   localparam logic [5:0]  IDX_RING_CTRL   = 6'h1E;
   localparam logic [5:0]  IDX_EVENT_CLEAR = 6'h1F;

   // identification word fields
   localparam int          ID_INDUSTRIAL   = 15;
   localparam int          ID_QUAD         = 14;
   localparam int          ID_PRECISION    = 13;
   localparam int          ID_ENCRYPT      = 12;
   localparam int          ID_DUAL_MEDIA   = 10;
   localparam int          ID_HIGH_PREC    = 9;
   localparam int          ID_KEY_256      = 8;
   localparam logic        CAP_QUAD        = 1'b1;
   localparam logic        CAP_PRECISION   = 1'b1;
   localparam logic        CAP_ENCRYPT     = 1'b1;
   localparam logic        CAP_DUAL_MEDIA  = 1'b1;
   localparam logic        CAP_HIGH_PREC   = 1'b1;
   localparam logic        CAP_KEY_256     = 1'b1;

   // event bit positions
   localparam int          EV_SWITCHOVER   = 4;

   // ring resiliency fields
   localparam int          RR_STARTUP      = 15;
   localparam int          RR_ADVERTISE    = 14;
   localparam int          RR_PARTNER      = 13;
   localparam int          RR_FORCE        = 12;
   localparam int          RR_ROLE_HI      = 5;
   localparam int          RR_ROLE_LO      = 4;
   localparam int          RR_START        = 0;

   // timing role codes
   localparam logic [1:0]  ROLE_SLAVE      = 2'h0;
   localparam logic [1:0]  ROLE_TO_MASTER  = 2'h2;
   localparam logic [1:0]  ROLE_MASTER     = 2'h3;
   localparam logic [1:0]  ROLE_TO_SLAVE   = 2'h1;

   // entropy generator
   localparam logic [15:0] LFSR_SEED       = 16'hACE1;
   localparam logic [15:0] LFSR_TAPS       = 16'hB400;

   // reset values
   localparam logic [10:0] MASK_RESET      = 11'h000;
   localparam logic [10:0] PEND_RESET      = 11'h000;

   typedef struct packed {
      logic       mem_ring;
      logic       encrypt_egress;
      logic       encrypt_ingress;
      logic       encrypt_fc_buffer;
      logic       encrypt_line_mac;
      logic       encrypt_host_mac;
      logic       eee_link_fail;
      logic       quiet_timer;
      logic       sleep_timer;
      logic       eee_wake_error;
   } ext_events_t;

   typedef struct packed {
      logic       link_up;
      logic       an_master;
      logic       link_partner_advert;
      logic       switchover_done;
   } ring_status_t;

   typedef struct packed {
      logic       startup_enable;
      logic       advertise;
      logic       force_enable;
      logic       switchover_start;
      logic [1:0] timing_role;
   } ring_ctrl_t;

endpackage : phy_ext_pkg

// [design/phy_ext_id_irq_ring_regs.sv]
// What this block does
// RL1: bit 15 of the identification word tells whether the part is industrial-temperature capable.
// RL2: identification bits 14, 13, 12, 10, 9 and 8 are fixed read-only capability flags.
// RL3: identification bits 7:0 carry the part's dash number in binary-coded decimal.
// RL4: every read of the entropy word returns 16 fresh random bits.
// RL5: mask bits 10:0 enable their interrupt sources when 1, hold their value and reset to zero.
// RL6: each pending bit reads 1 while its event is outstanding and clears once it has been read.
// RL7: event bits 10 to 5 belong to memory ring, egress, ingress, buffer, line MAC and host MAC.
// RL8: event bit 4 is raised when a commanded timing-role switchover finishes.
// RL9: event bits 3 to 0 are link fail, quiet timer, sleep timer and wake error.
// RL10: ring bits 15, 14, 12 are held control bits and bit 13 shows the partner's advertisement.
// RL11: ring bits 5:4 hold the timing role, 00 slave, 10 to master, 11 master, 01 to slave, reset 00.
// RL12: at the first link-up the role settles to the master or slave outcome of autonegotiation.
// RL13: writing 1 to ring bit 0 starts a switchover only while none is in progress, then clears.
// RL14: reserved bits read zero and writes to them do nothing.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module phy_ext_id_irq_ring_regs
   import phy_ext_pkg::*;
#(
   parameter logic       industrial_temp = 1'b0,
   parameter logic [7:0] dash_bcd        = 8'h00   // arbitrary variant code
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [DATA_W-1:0] writedata,
   input  wire logic [3:0]        byteenable,
   output logic      [DATA_W-1:0] readdata,
   output logic                   waitrequest,
   input  wire ext_events_t       events,
   input  wire ring_status_t      ring_status,
   output ring_ctrl_t             ring_ctrl,
   output logic                   irq
);

   typedef struct packed {
      logic [10:0]       mask;
      logic [10:0]       pending;
      logic              startup_enable;
      logic              advertise;
      logic              force_enable;
      logic [1:0]        role;
      logic              link_seen;
      logic              start_pulse;
      logic [15:0]       lfsr;
      logic              ack;
      logic [DATA_W-1:0] rdata;
   } state_t;

   state_t            st;
   state_t            next_st;
   logic [IDX_W-1:0]  idx;
   logic              req;
   logic              wr_done;
   logic              rd_done;
   logic [REG_W-1:0]  wmask;
   logic [REG_W-1:0]  wval;
   logic [10:0]       raw_events;
   logic [REG_W-1:0]  id_word;
   logic [REG_W-1:0]  ring_word;
   logic              role_settled;
   logic              sel_mask;
   logic              sel_pend;
   logic              sel_ring;
   logic              sel_clear;
   logic              rd_wait;
   logic [REG_W-1:0]  rd_word;
   logic [10:0]       set_bits;
   logic [10:0]       clr_bits;
   logic [10:0]       next_pending;
   logic [10:0]       next_mask;
   logic [10:0]       irq_bits;
   logic              next_startup;
   logic              next_advertise;
   logic              next_force;
   logic [1:0]        next_role;
   logic              first_up;
   logic              start_ok;
   logic              finish;
   logic [15:0]       next_lfsr;

   // word index from the byte address
   assign idx     = address[ADDR_W-1:2];
   assign req     = read | write;
   assign wr_done = write & st.ack;
   assign rd_done = read & st.ack;

   // lane 0 and 1 cover the 16-bit register
   assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
   assign wval  = writedata[REG_W-1:0] & wmask;

   // one wait cycle, answer on the second edge
   assign waitrequest = req & ~st.ack;

   assign raw_events = {
      events.mem_ring,                       // [RL7]
      events.encrypt_egress,
      events.encrypt_ingress,
      events.encrypt_fc_buffer,
      events.encrypt_line_mac,
      events.encrypt_host_mac,
      1'b0,
      events.eee_link_fail,                  // [RL9]
      events.quiet_timer,
      events.sleep_timer,
      events.eee_wake_error
   };

   always_comb begin
      id_word                = '0;
      id_word[ID_INDUSTRIAL] = industrial_temp;        // [RL1]
      id_word[ID_QUAD]       = CAP_QUAD;               // [RL2]
      id_word[ID_PRECISION]  = CAP_PRECISION;          // [RL2]
      id_word[ID_ENCRYPT]    = CAP_ENCRYPT;            // [RL2]
      id_word[ID_DUAL_MEDIA] = CAP_DUAL_MEDIA;         // [RL2]
      id_word[ID_HIGH_PREC]  = CAP_HIGH_PREC;          // [RL2]
      id_word[ID_KEY_256]    = CAP_KEY_256;            // [RL2]
      id_word[7:0]           = dash_bcd;               // [RL3]
   end

   always_comb begin
      ring_word                        = '0;           // [RL14]
      ring_word[RR_STARTUP]            = st.startup_enable;
      ring_word[RR_ADVERTISE]          = st.advertise;
      ring_word[RR_PARTNER]            = ring_status.link_partner_advert; // [RL10]
      ring_word[RR_FORCE]              = st.force_enable;
      ring_word[RR_ROLE_HI:RR_ROLE_LO] = st.role;      // [RL11]
   end

   assign role_settled = (st.role == ROLE_SLAVE) | (st.role == ROLE_MASTER);

   // one select per written or cleared register
   assign sel_mask  = (idx == IDX_EVENT_MASK);
   assign sel_pend  = (idx == IDX_EVENT_PEND);
   assign sel_ring  = (idx == IDX_RING_CTRL);
   assign sel_clear = (idx == IDX_EVENT_CLEAR);
   assign rd_wait   = read & ~st.ack;

   // read word, picked in the wait cycle
   always_comb begin
      case (idx)
         IDX_PART_ID: begin
            rd_word = id_word;
         end
         IDX_ENTROPY: begin
            rd_word = st.lfsr;                         // [RL4]
         end
         IDX_EVENT_MASK: begin
            rd_word = {5'h00, st.mask};                // [RL14]
         end
         IDX_EVENT_PEND: begin
            rd_word = {5'h00, st.pending};             // [RL6]
         end
         IDX_RING_CTRL: begin
            rd_word = ring_word;
         end
         default: begin
            rd_word = '0;                              // [RL14]
         end
      endcase
   end

   // clears come from the clear word or from a finished pending read
   always_comb begin
      clr_bits = '0;
      if (wr_done && sel_clear) begin
         clr_bits = wval[10:0];
      end
      // only bits already handed out are dropped, a later event stays pending
      if (rd_done && sel_pend) begin
         clr_bits = st.rdata[10:0];                    // [RL6]
      end
   end

   // first link-up beats a start, a start beats a finish
   assign first_up = ~st.link_seen & ring_status.link_up;
   assign start_ok = wr_done & sel_ring & wval[RR_START] & role_settled & st.link_seen; // [RL13]
   assign finish   = ~first_up & ~start_ok & ~role_settled & ring_status.switchover_done;

   always_comb begin
      set_bits                = raw_events;
      set_bits[EV_SWITCHOVER] = finish;                // [RL8]
   end

   // timing role machine
   always_comb begin
      next_role = st.role;
      if (first_up) begin
         next_role = ring_status.an_master ? ROLE_MASTER : ROLE_SLAVE;         // [RL12]
      end else if (start_ok) begin
         next_role = (st.role == ROLE_SLAVE) ? ROLE_TO_MASTER : ROLE_TO_SLAVE; // [RL11]
      end else if (finish) begin
         next_role = (st.role == ROLE_TO_MASTER) ? ROLE_MASTER : ROLE_SLAVE;   // [RL11]
      end
   end

   // held control bits, all three behind byte lane 1
   always_comb begin
      next_startup   = st.startup_enable;
      next_advertise = st.advertise;
      next_force     = st.force_enable;
      if (wr_done && sel_ring) begin
         if (wmask[RR_STARTUP]) begin
            next_startup = wval[RR_STARTUP];           // [RL10]
         end
         if (wmask[RR_ADVERTISE]) begin
            next_advertise = wval[RR_ADVERTISE];       // [RL10]
         end
         if (wmask[RR_FORCE]) begin
            next_force = wval[RR_FORCE];               // [RL10]
         end
      end
   end

   // per-source mask and pending bits, a fresh event beats a clear in the same cycle
   for (genvar gi = 0; gi < NUM_EVENTS; gi++) begin : g_event
      assign next_mask[gi]    = (wr_done & sel_mask & wmask[gi]) ? wval[gi] : st.mask[gi]; // [RL5]
      assign next_pending[gi] = (st.pending[gi] & ~clr_bits[gi]) | set_bits[gi];          // [RL6]
      assign irq_bits[gi]     = st.pending[gi] & st.mask[gi];                             // [RL5]
   end

   // entropy keeps running so back-to-back reads differ
   assign next_lfsr = st.lfsr[0] ? ((st.lfsr >> 1) ^ LFSR_TAPS) : (st.lfsr >> 1); // [RL4]

   always_comb begin
      next_st                = st;
      next_st.lfsr           = next_lfsr;
      // acknowledge toggles through a two-cycle access
      next_st.ack            = req & ~st.ack;
      next_st.mask           = next_mask;
      next_st.pending        = next_pending;
      next_st.startup_enable = next_startup;
      next_st.advertise      = next_advertise;
      next_st.force_enable   = next_force;
      next_st.role           = next_role;
      next_st.start_pulse    = start_ok;               // [RL13]
      next_st.link_seen      = st.link_seen | ring_status.link_up;
      // read data latched in the wait cycle
      if (rd_wait) begin
         next_st.rdata = {16'h0000, rd_word};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st.mask           <= MASK_RESET;              // [RL5]
         st.pending        <= PEND_RESET;
         st.startup_enable <= 1'b0;
         st.advertise      <= 1'b0;
         st.force_enable   <= 1'b0;
         st.role           <= ROLE_SLAVE;              // [RL11]
         st.link_seen      <= 1'b0;
         st.start_pulse    <= 1'b0;
         st.lfsr           <= LFSR_SEED;
         st.ack            <= 1'b0;
         st.rdata          <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign readdata                   = st.rdata;
   assign irq                        = |irq_bits;      // [RL5]
   assign ring_ctrl.startup_enable   = st.startup_enable;
   assign ring_ctrl.advertise        = st.advertise;
   assign ring_ctrl.force_enable     = st.force_enable;
   assign ring_ctrl.switchover_start = st.start_pulse;
   assign ring_ctrl.timing_role      = st.role;

endmodule : phy_ext_id_irq_ring_regs

// [verif/phy_ext_regs_properties.sv]
`timescale 1ns/1ps
module phy_ext_regs_properties
   import phy_ext_pkg::*;
#(
   parameter logic       industrial_temp = 1'h0,
   parameter logic [7:0] dash_bcd        = 8'h00
) (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic              read,
   input wire logic              write,
   input wire logic [DATA_W-1:0] writedata,
   input wire logic [3:0]        byteenable,
   input wire logic [DATA_W-1:0] readdata,
   input wire logic              waitrequest,
   input wire ext_events_t       events,
   input wire ring_status_t      ring_status,
   input wire ring_ctrl_t        ring_ctrl,
   input wire logic              irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd(logic [7:0] a);
      read && !waitrequest && address == a;
   endsequence
   sequence s_wr(logic [7:0] a);
      write && !waitrequest && address == a;
   endsequence
   property p_wait;
      $rose(read || write) |-> waitrequest ##1 !waitrequest;
   endproperty
   property p_id;
      s_rd(8'h48) |-> readdata == {16'h0000, industrial_temp, CAP_QUAD, CAP_PRECISION, CAP_ENCRYPT, 1'h0,
                                   CAP_DUAL_MEDIA, CAP_HIGH_PREC, CAP_KEY_256, dash_bcd};
   endproperty
   property p_upper;
      read && !waitrequest |-> readdata[31:16] == 16'h0000;
   endproperty
   property p_mask_rsvd;
      s_rd(8'h70) |-> readdata[15:11] == 5'h00;
   endproperty
   property p_ring_read;
      s_rd(8'h78) |-> readdata[13] == $past(ring_status.link_partner_advert)
         && readdata[5:4] == $past(ring_ctrl.timing_role) && readdata[11:6] == 6'h00 && readdata[3:0] == 4'h0;
   endproperty
   property p_start_pulse;
      ring_ctrl.switchover_start |=> !ring_ctrl.switchover_start;
   endproperty
   property p_start_cause;
      $rose(ring_ctrl.switchover_start) |-> $past(write && !waitrequest && address == 8'h78
         && writedata[0] && byteenable[0]);
   endproperty
   property p_start_role;
      ring_ctrl.switchover_start |-> (ring_ctrl.timing_role == ROLE_TO_MASTER && $past(ring_ctrl.timing_role) == ROLE_SLAVE)
         || (ring_ctrl.timing_role == ROLE_TO_SLAVE && $past(ring_ctrl.timing_role) == ROLE_MASTER);
   endproperty
   property p_done;
      (ring_ctrl.timing_role == ROLE_TO_MASTER || ring_ctrl.timing_role == ROLE_TO_SLAVE) && ring_status.switchover_done
         |=> ring_ctrl.timing_role == {$past(ring_ctrl.timing_role[1]), $past(ring_ctrl.timing_role[1])};
   endproperty
   property p_read_clear;
      s_rd(8'h74) and (events == '0 && !ring_status.switchover_done && $past(events) == '0
         && !$past(ring_status.switchover_done)) |=> !irq;
   endproperty
   property p_reg_clear;
      s_wr(8'h7C) and (writedata[10:0] == 11'h7FF && byteenable[1:0] == 2'h3 && events == '0
         && !ring_status.switchover_done) |=> !irq;
   endproperty
   a_wait: assert property (p_wait) else $error("waitrequest not one cycle");
   a_id: assert property (p_id) else $error("identification word wrong");
   a_upper: assert property (p_upper) else $error("upper read half not zero");
   a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask reserved bits set");
   a_ring_read: assert property (p_ring_read) else $error("ring word wrong");
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
   a_start_cause: assert property (p_start_cause) else $error("start without write");
   a_start_role: assert property (p_start_role) else $error("start role step wrong");
   a_done: assert property (p_done) else $error("role did not settle");
   a_read_clear: assert property (p_read_clear) else $error("irq after pending read");
   a_reg_clear: assert property (p_reg_clear) else $error("irq after clear write");
endmodule : phy_ext_regs_properties

// [verif/phy_ext_id_irq_ring_regs_bench.sv]
`timescale 1ns/1ps
module phy_ext_id_irq_ring_regs_bench import phy_ext_pkg::*;;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [15:0] d;
      logic [31:0] e;
   } row_t;
   logic              clk             = 1'h0;
   logic              rst_n           = 1'h0;
   logic [ADDR_W-1:0] address         = '0;
   logic              read            = 1'h0;
   logic              write           = 1'h0;
   logic [DATA_W-1:0] writedata       = '0;
   logic [3:0]        byteenable      = 4'hF;
   logic [DATA_W-1:0] readdata;
   logic              waitrequest;
   ext_events_t       events          = '0;
   ring_status_t      ring_status     = '0;
   ring_ctrl_t        ring_ctrl;
   logic              irq;
   logic [31:0]       q;
   logic [31:0]       q2;
   int                fails           = 0;
   int                samples_checked = 0;
   row_t              rows [11]       = '{'{1'h0, 8'h48, 16'h0, 32'hF727}, '{1'h0, 8'h70, 16'h0, 32'h0},
      '{1'h0, 8'h74, 16'h0, 32'h0}, '{1'h0, 8'h78, 16'h0, 32'h0}, '{1'h1, 8'h70, 16'hFFFF, 32'h0},
      '{1'h0, 8'h70, 16'h0, 32'h7FF}, '{1'h1, 8'h78, 16'hF0FF, 32'h0}, '{1'h0, 8'h78, 16'h0, 32'hD000},
      '{1'h1, 8'h48, 16'hFFFF, 32'h0}, '{1'h0, 8'h40, 16'h0, 32'h0}, '{1'h0, 8'h48, 16'h0, 32'hF727}};
   always #5 clk = ~clk;
   phy_ext_id_irq_ring_regs #(.industrial_temp(1'h1), .dash_bcd(8'h27)) i_dut ( // arbitrary variant code
      .clk, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
      .events, .ring_status, .ring_ctrl, .irq);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   // entered just after a rising edge; data taken at the edge that sees waitrequest low
   // hold keeps the request for a back-to-back access
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, input logic hold);
      int n;
      n = 0;
      read <= ~w;
      write <= w;
      address <= a;
      writedata <= {16'h0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'h0 && n < 20);
      if (waitrequest !== 1'h0) begin
         fails++;
         stop_test();
      end
      q = readdata;
      if (!hold) begin
         read <= 1'h0;
         write <= 1'h0;
         @(posedge clk);
      end
   endtask : acc
   task automatic pulse_ev(input ext_events_t v);
      events <= v;
      @(posedge clk);
      events <= '0;
      @(negedge clk);
   endtask : pulse_ev
   task automatic pulse_done();
      ring_status.switchover_done <= 1'h1;
      @(posedge clk);
      ring_status.switchover_done <= 1'h0;
   endtask : pulse_done
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      for (int i = 0; i < 11; i++) begin
         acc(rows[i].w, rows[i].a, rows[i].d, 1'h0);
         if (!rows[i].w) chk(q, rows[i].e);
      end
      $display("register rows done");
      for (int j = 0; j < 10; j++) begin
         pulse_ev(ext_events_t'(10'h001 << j));
         chk({31'h0, irq}, 32'h1);
         @(posedge clk);
         acc(1'h0, 8'h74, 16'h0, 1'h0);
         chk(q, 32'h1 << (j < 4 ? j : j + 1));
         chk({31'h0, irq}, 32'h0);
         acc(1'h0, 8'h74, 16'h0, 1'h0);
         chk(q, 32'h0);
      end
      byteenable <= 4'h1;
      acc(1'h1, 8'h70, 16'h0, 1'h0);
      byteenable <= 4'hF;
      acc(1'h0, 8'h70, 16'h0, 1'h0);
      chk(q, 32'h700);
      pulse_ev(ext_events_t'(10'h001));
      chk({31'h0, irq}, 32'h0);
      @(posedge clk);
      pulse_ev(ext_events_t'(10'h200));
      chk({31'h0, irq}, 32'h1);
      @(posedge clk);
      acc(1'h1, 8'h7C, 16'h07FF, 1'h0);
      acc(1'h0, 8'h74, 16'h0, 1'h0);
      chk(q, 32'h0);
      $display("event tests done");
      ring_status.link_up <= 1'h1;
      ring_status.link_partner_advert <= 1'h1;
      @(posedge clk);
      for (int k = 0; k < 2; k++) begin
         acc(1'h1, 8'h78, 16'hD001, 1'h0);
         acc(1'h1, 8'h78, 16'hD001, 1'h0);
         acc(1'h0, 8'h78, 16'h0, 1'h0);
         chk(q, k ? 32'hF010 : 32'hF020);
         pulse_done();
         acc(1'h0, 8'h78, 16'h0, 1'h0);
         chk(q, k ? 32'hF000 : 32'hF030);
         acc(1'h0, 8'h74, 16'h0, 1'h0);
         chk(q, 32'h10);
      end
      chk({26'h0, ring_ctrl}, 32'h38);
      acc(1'h0, 8'h4C, 16'h0, 1'h1);
      q2 = q;
      acc(1'h0, 8'h4C, 16'h0, 1'h0);
      chk({31'h0, q !== q2}, 32'h1);
      $display("ring and entropy tests done");
      rst_n <= 1'h0;
      ring_status.an_master <= 1'h1;
      ring_status.link_up <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      ring_status.link_up <= 1'h1;
      @(posedge clk);
      acc(1'h0, 8'h78, 16'h0, 1'h0);
      chk(q, 32'h2030);
      acc(1'h0, 8'h70, 16'h0, 1'h0);
      chk(q, 32'h0);
      $display("second reset test done");
      stop_test();
   end
endmodule : phy_ext_id_irq_ring_regs_bench
bind phy_ext_id_irq_ring_regs phy_ext_regs_properties #(.industrial_temp(industrial_temp), .dash_bcd(dash_bcd))
   i_props (.clk, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
            .events, .ring_status, .ring_ctrl, .irq);
